// ===== logic/m8ace_defines.svh
// constants for the add / and / call / clear execute block
`ifndef M8ACE_DEFINES_SVH
`define M8ACE_DEFINES_SVH

`define M8ACE_OFS_CTRL      12'h000
`define M8ACE_OFS_STATUS    12'h004
`define M8ACE_OFS_PC        12'h008
`define M8ACE_OFS_PORTS     12'h00C
`define M8ACE_OFS_DMEM      12'h100

`define M8ACE_CTRL_RUN      0
`define M8ACE_CTRL_BANKFLAG 1
`define M8ACE_CTRL_REGBANK  2
`define M8ACE_STAT_F1       16
`define M8ACE_STAT_UNIMPL   17

`define M8ACE_PC_RST        12'h000
`define M8ACE_PORT_RST      8'hFF
`define M8ACE_STACK_BASE    8'h08
`define M8ACE_BANK1_BASE    8'h18

`define M8ACE_OP_ADD_IMM    8'h03
`define M8ACE_OP_ADD_WITH_CARRY_TO_ACC_IMM   8'h13
`define M8ACE_OP_AND_IMM    8'h53
`define M8ACE_OP_AND_BUS    8'h98
`define M8ACE_OP_AND_P1     8'h99
`define M8ACE_OP_AND_P2     8'h9A
`define M8ACE_OP_CLR_A      8'h27
`define M8ACE_OP_CLR_C      8'h97
`define M8ACE_OP_CLR_F0     8'h85
`define M8ACE_OP_CLR_F1     8'hA5

`endif

// ===== logic/m8ace_pkg.sv
// types shared by the execute core and its arithmetic unit
`default_nettype none
package m8ace_pkg;
  typedef enum logic [1:0] {
    ST_HALT  = 2'b00,
    ST_FETCH = 2'b01,
    ST_OPER  = 2'b10
  } m8ace_state_t;

  typedef enum logic [1:0] {
    ALU_ADD  = 2'b00,
    ALU_ADD_WITH_CARRY_TO_ACC = 2'b01,
    ALU_AND  = 2'b10
  } m8ace_alu_op_t;
endpackage : m8ace_pkg
`default_nettype wire

// ===== logic/m8ace_alu_if.sv
// operand and result bundle between the core and the arithmetic unit
`timescale 1ns/100ps
`default_nettype none
interface m8ace_alu_if;
  m8ace_pkg::m8ace_alu_op_t op;
  logic [7:0]               a;
  logic [7:0]               b;
  logic                     cin;
  logic [7:0]               res;
  logic                     cout;
  logic                     hout;
  modport core (output op, a, b, cin, input res, cout, hout);
  modport alu  (input op, a, b, cin, output res, cout, hout);
endinterface : m8ace_alu_if
`default_nettype wire

// ===== logic/m8ace_alu.sv
// arithmetic unit: add, add with carry, bitwise and
`timescale 1ns/100ps
`default_nettype none
module m8ace_alu (
  m8ace_alu_if.alu io   // operands in, result and flags out
);
  logic [8:0] sum;
  logic [4:0] half;

  always_comb begin
    // operand added first, then the carry; carry out is from the final sum
    sum  = {1'b0, io.a} + {1'b0, io.b} +
           {8'h00, (io.op == m8ace_pkg::ALU_ADD_WITH_CARRY_TO_ACC) ? io.cin : 1'b0};
    half = {1'b0, io.a[3:0]} + {1'b0, io.b[3:0]} +
           {4'h0, (io.op == m8ace_pkg::ALU_ADD_WITH_CARRY_TO_ACC) ? io.cin : 1'b0};
    if (io.op == m8ace_pkg::ALU_AND) begin
      io.res = io.a & io.b;
    end else begin
      io.res = sum[7:0];
    end
    io.cout = sum[8];
    io.hout = half[4];
  end
endmodule : m8ace_alu
`default_nettype wire

// ===== logic/m8ace_top.sv
// execute core for add, and, call and clear instructions with apb access
//
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "m8ace_defines.svh"

module m8ace_top #(
  parameter int DMEM_AW = 6   // 6 for 64-byte memory, 7 for the larger variant
) (
  input  wire logic        CORE_CLK,      // core clock, one machine cycle per rising edge
  input  wire logic        NRST,          // synchronous reset, active low
  input  wire logic        PSEL,          // apb select
  input  wire logic        PENABLE,       // apb access phase
  input  wire logic        PWRITE,        // apb direction, high for write
  input  wire logic [11:0] PADDR,         // apb byte address
  input  wire logic [31:0] PWDATA,        // apb write data
  output logic      [31:0] PRDATA,        // apb read data
  output logic             PREADY,        // apb ready, always high
  output logic             PSLVERR,       // apb error on unmapped address
  output logic      [11:0] PMEM_ADDR,     // program memory address
  input  wire logic [7:0]  PMEM_DATA,     // program memory byte at PMEM_ADDR
  output logic      [7:0]  BUS_OUT,       // bus port output latch
  input  wire logic [7:0]  P1_IN,         // port 1 pins
  output logic      [7:0]  P1_OUT,        // port 1 output latch
  input  wire logic [7:0]  P2_IN,         // port 2 pins
  output logic      [7:0]  P2_OUT,        // port 2 output latch
  output logic             EXP_AND_STB,   // expander and command strobe
  output logic      [1:0]  EXP_PORT,      // expander port, 0 means port 4
  output logic      [3:0]  EXP_NIBBLE     // mask sent with the expander command
);
  localparam int DEPTH = 1 << DMEM_AW;

  typedef struct packed {
    m8ace_pkg::m8ace_state_t   st;
    logic [7:0]                opc;
    logic [11:0]               pc;
    logic [7:0]                acc;
    logic                      cy;
    logic                      hc;
    logic                      f0;
    logic                      f1;
    logic                      bs;
    logic [2:0]                sp;
    logic                      bank_flag_latch;
    logic                      run;
    logic                      unimpl;
    logic [7:0]                bus_lat;
    logic [7:0]                p1_lat;
    logic [7:0]                p2_lat;
    logic                      exp_stb;
    logic [1:0]                exp_port;
    logic [3:0]                exp_nib;
    logic [31:0]               prdata;
    logic                      pslverr;
    logic [DEPTH-1:0][7:0]     ram;
  } m8ace_core_t;

  m8ace_core_t r_r;
  m8ace_core_t r_nxt;
  m8ace_alu_if alu_bus ();

  m8ace_alu m8ace_alu_i (
    .io (alu_bus.alu)
  );

  // counter increments within its 2K bank; bit 11 only moves on a call or a host write to the PC register
  function automatic logic [11:0] pc_inc(input logic [11:0] pc);
    logic [10:0] low;
    low = pc[10:0] + 11'h001;
    return {pc[11], low};
  endfunction : pc_inc

  function automatic logic [DMEM_AW-1:0] reg_addr(input logic bs, input logic [2:0] idx);
    logic [7:0] full;
    full = (bs ? `M8ACE_BANK1_BASE : 8'h00) + {5'h00, idx};
    return full[DMEM_AW-1:0];
  endfunction : reg_addr

  function automatic logic [7:0] status_word(input m8ace_core_t s);
    return {s.cy, s.hc, s.f0, s.bs, 1'b1, s.sp};
  endfunction : status_word

  // one aligned word per memory byte; a misaligned hit falls through to unmapped
  function automatic logic dmem_hit(input logic [11:0] a);
    return (a >= `M8ACE_OFS_DMEM) && (a < `M8ACE_OFS_DMEM + 12'(DEPTH * 4)) && (a[1:0] == 2'b00);
  endfunction : dmem_hit

  function automatic logic [DMEM_AW-1:0] dmem_idx(input logic [11:0] a);
    logic [11:0] off;
    off = a - `M8ACE_OFS_DMEM;
    return off[DMEM_AW+1:2];
  endfunction : dmem_idx

  // operand path: current opcode is the fetched byte or the latched one
  logic [7:0]         cur_op;
  logic [7:0]         ptr;
  logic [DMEM_AW-1:0] ind_addr;
  logic [7:0]         operand;

  always_comb begin
    cur_op = (r_r.st == m8ace_pkg::ST_OPER) ? r_r.opc : PMEM_DATA;
    ptr      = r_r.ram[reg_addr(r_r.bs, {2'b00, cur_op[0]})];
    ind_addr = ptr[DMEM_AW-1:0];
    if (r_r.st == m8ace_pkg::ST_OPER) begin
      operand = PMEM_DATA;
    end else if (cur_op[3]) begin
      operand = r_r.ram[reg_addr(r_r.bs, cur_op[2:0])];
    end else begin
      operand = r_r.ram[ind_addr];
    end
    unique case (cur_op[7:4])
      4'h0, 4'h6: alu_bus.op = m8ace_pkg::ALU_ADD;
      4'h1, 4'h7: alu_bus.op = m8ace_pkg::ALU_ADD_WITH_CARRY_TO_ACC;
      default:    alu_bus.op = m8ace_pkg::ALU_AND;
    endcase
    alu_bus.a   = r_r.acc;
    alu_bus.b   = operand;
    alu_bus.cin = r_r.cy;
  end

  // apb decode
  // writes commit on the access edge only, so an abandoned setup never lands
  logic        apb_setup;
  logic        apb_wr;
  logic        hit_reg;
  logic [31:0] rd_val;

  always_comb begin
    apb_setup = PSEL && !PENABLE;
    apb_wr    = PSEL && PENABLE && PWRITE;
    hit_reg   = 1'b1;
    rd_val    = 32'h0000_0000;
    if (dmem_hit(PADDR)) begin
      rd_val = {24'h000000, r_r.ram[dmem_idx(PADDR)]};
    end else begin
      unique case (PADDR)
        `M8ACE_OFS_CTRL:   rd_val = {29'h0000_0000, r_r.bs, r_r.bank_flag_latch, r_r.run};
        `M8ACE_OFS_STATUS: rd_val = {14'h0000, r_r.unimpl, r_r.f1, status_word(r_r), r_r.acc};
        `M8ACE_OFS_PC:     rd_val = {20'h00000, r_r.pc};
        `M8ACE_OFS_PORTS:  rd_val = {8'h00, r_r.p2_lat, r_r.p1_lat, r_r.bus_lat};
        default:           hit_reg = 1'b0;
      endcase
    end
  end

  logic [11:0]        ret_pc;
  logic [DMEM_AW-1:0] stk_lo;
  logic [DMEM_AW-1:0] stk_hi;
  logic [7:0]         stk_full;
  logic [7:0]         psw_now;

  always_comb begin
    r_nxt       = r_r;
    r_nxt.exp_stb = 1'b0;
    ret_pc      = pc_inc(r_r.pc);
    // two bytes per stack slot from 8 up; three pointer bits give eight slots
    stk_full    = `M8ACE_STACK_BASE + {4'h0, r_r.sp, 1'b0};
    stk_lo      = stk_full[DMEM_AW-1:0];
    stk_hi      = stk_lo + DMEM_AW'(1);
    psw_now     = status_word(r_r);

    // read data is captured in the setup cycle so it comes from a flop
    if (apb_setup) begin
      r_nxt.prdata  = hit_reg ? rd_val : 32'h0000_0000;
      r_nxt.pslverr = !hit_reg;
    end
    // host loads of memory and machine state, except the bank flag and bank select written through CTRL, are dropped while run is set so they never race execution
    if (apb_wr && hit_reg) begin
      if (dmem_hit(PADDR)) begin
        if (!r_r.run) begin
          r_nxt.ram[dmem_idx(PADDR)] = PWDATA[7:0];
        end
      end else begin
        unique case (PADDR)
          `M8ACE_OFS_CTRL: begin
            r_nxt.run             = PWDATA[`M8ACE_CTRL_RUN];
            r_nxt.bank_flag_latch = PWDATA[`M8ACE_CTRL_BANKFLAG];
            r_nxt.bs              = PWDATA[`M8ACE_CTRL_REGBANK];
          end
          `M8ACE_OFS_STATUS: begin
            // machine state only loads while halted; the sticky bit clears on a one
            if (!r_r.run) begin
              r_nxt.acc = PWDATA[7:0];
              r_nxt.cy  = PWDATA[15];
              r_nxt.hc  = PWDATA[14];
              r_nxt.f0  = PWDATA[13];
              r_nxt.bs  = PWDATA[12];
              r_nxt.sp  = PWDATA[10:8];
              r_nxt.f1  = PWDATA[`M8ACE_STAT_F1];
            end
            if (PWDATA[`M8ACE_STAT_UNIMPL]) begin
              r_nxt.unimpl = 1'b0;
            end
          end
          `M8ACE_OFS_PC: begin
            if (!r_r.run) begin
              r_nxt.pc = PWDATA[11:0];
            end
          end
          default: ;
        endcase
      end
    end

    // halting only between instructions keeps a two-byte form from being split
    unique case (r_r.st)
      m8ace_pkg::ST_HALT: begin
        if (r_r.run) begin
          r_nxt.st = m8ace_pkg::ST_FETCH;
        end
      end
      m8ace_pkg::ST_FETCH: begin
        if (!r_r.run) begin
          r_nxt.st = m8ace_pkg::ST_HALT;
        end else begin
          r_nxt.pc = ret_pc;
          // one-cycle forms finish here; two-byte forms park the opcode in opc
          casez (PMEM_DATA)
            8'b0110_1???, 8'b0110_000?: begin
              r_nxt.acc = alu_bus.res;
              r_nxt.cy  = alu_bus.cout;
              r_nxt.hc  = alu_bus.hout;
            end
            // add with carry, one cycle forms
            8'b0111_1???, 8'b0111_000?: begin
              r_nxt.acc = alu_bus.res;
              r_nxt.cy  = alu_bus.cout;
              r_nxt.hc  = alu_bus.hout;
            end
            8'b0101_1???, 8'b0101_000?: begin
              r_nxt.acc = alu_bus.res;
            end
            // two-cycle forms latch the opcode; all but the expander command fetch the operand next
            `M8ACE_OP_ADD_IMM, `M8ACE_OP_ADD_WITH_CARRY_TO_ACC_IMM, `M8ACE_OP_AND_IMM,
            `M8ACE_OP_AND_BUS, `M8ACE_OP_AND_P1, `M8ACE_OP_AND_P2,
            8'b1001_11??, 8'b???1_0100: begin
              r_nxt.opc = PMEM_DATA;
              r_nxt.st  = m8ace_pkg::ST_OPER;
            end
            `M8ACE_OP_CLR_A: r_nxt.acc = 8'h00;
            `M8ACE_OP_CLR_C: r_nxt.cy = 1'b0;
            `M8ACE_OP_CLR_F0: r_nxt.f0 = 1'b0;
            `M8ACE_OP_CLR_F1: r_nxt.f1 = 1'b0;
            // anything outside the group runs as a one-cycle no-op and is flagged
            default: r_nxt.unimpl = 1'b1;
          endcase
        end
      end
      m8ace_pkg::ST_OPER: begin
        r_nxt.pc = ret_pc;
        r_nxt.st = m8ace_pkg::ST_FETCH;
        casez (r_r.opc)
          // immediate add and add with carry
          `M8ACE_OP_ADD_IMM, `M8ACE_OP_ADD_WITH_CARRY_TO_ACC_IMM: begin
            r_nxt.acc = alu_bus.res;
            r_nxt.cy  = alu_bus.cout;
            r_nxt.hc  = alu_bus.hout;
          end
          `M8ACE_OP_AND_IMM: r_nxt.acc = alu_bus.res;
          `M8ACE_OP_AND_BUS: r_nxt.bus_lat = r_r.bus_lat & PMEM_DATA;
          // port read at the pins, result stays latched
          `M8ACE_OP_AND_P1: r_nxt.p1_lat = P1_IN & PMEM_DATA;
          `M8ACE_OP_AND_P2: r_nxt.p2_lat = P2_IN & PMEM_DATA;
          // expander command issued in the second cycle; no operand byte
          8'b1001_11??: begin
            r_nxt.pc       = r_r.pc;
            r_nxt.exp_stb  = 1'b1;
            r_nxt.exp_port = r_r.opc[1:0];
            r_nxt.exp_nib  = r_r.acc[3:0];
          end
          8'b???1_0100: begin
            // push return address and upper status
            r_nxt.ram[stk_lo] = ret_pc[7:0];
            r_nxt.ram[stk_hi] = {psw_now[7:4], ret_pc[11:8]};
            r_nxt.sp          = r_r.sp + 3'h1;
            // target from opcode, operand byte and bank flag
            r_nxt.pc = {r_r.bank_flag_latch, r_r.opc[7:5], PMEM_DATA};
          end
          default: ;
        endcase
      end
      default: r_nxt.st = m8ace_pkg::ST_HALT;
    endcase
  end

  // reset leaves the core halted with all port latches high
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      r_r         <= '0;
      r_r.st      <= m8ace_pkg::ST_HALT;
      r_r.pc      <= `M8ACE_PC_RST;
      r_r.bus_lat <= `M8ACE_PORT_RST;
      r_r.p1_lat  <= `M8ACE_PORT_RST;
      r_r.p2_lat  <= `M8ACE_PORT_RST;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign PRDATA      = r_r.prdata;
  // zero wait states: read data was already captured in the setup cycle
  assign PREADY      = 1'b1;
  assign PSLVERR     = r_r.pslverr;
  assign PMEM_ADDR   = r_r.pc;
  assign BUS_OUT     = r_r.bus_lat;
  assign P1_OUT      = r_r.p1_lat;
  assign P2_OUT      = r_r.p2_lat;
  assign EXP_AND_STB = r_r.exp_stb;
  assign EXP_PORT    = r_r.exp_port;
  assign EXP_NIBBLE  = r_r.exp_nib;
endmodule : m8ace_top
`default_nettype wire

// ===== test/m8ace_top_chk.sv
// concurrent checks on the execute block's ports
`timescale 1ns/100ps
`default_nettype none
module m8ace_top_chk (
  input wire logic        CORE_CLK,     // core clock
  input wire logic        NRST,         // synchronous reset, active low
  input wire logic        PSEL,         // apb select
  input wire logic        PENABLE,      // apb access phase
  input wire logic        PWRITE,       // apb direction
  input wire logic [31:0] PRDATA,       // apb read data
  input wire logic        PREADY,       // apb ready
  input wire logic [11:0] PMEM_ADDR,    // program counter
  input wire logic [7:0]  PMEM_DATA,    // program byte
  input wire logic [7:0]  BUS_OUT,      // bus latch
  input wire logic [7:0]  P1_IN,        // port 1 pins
  input wire logic [7:0]  P1_OUT,       // port 1 latch
  input wire logic [7:0]  P2_IN,        // port 2 pins
  input wire logic [7:0]  P2_OUT,       // port 2 latch
  input wire logic        EXP_AND_STB,  // expander strobe
  input wire logic [1:0]  EXP_PORT,     // expander port
  input wire logic [3:0]  EXP_NIBBLE    // expander mask
);
  // last two program bytes, oldest in d2_r
  logic [7:0] d1_r;
  logic [7:0] d2_r;
  always_ff @(posedge CORE_CLK) begin
    d1_r <= PMEM_DATA;
    d2_r <= d1_r;
  end

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);

  // a non-sequential counter step not caused by a bus write; bank wrap excluded
  sequence call_jump;
    PMEM_ADDR != $past(PMEM_ADDR) && PMEM_ADDR != $past(PMEM_ADDR) + 12'h001 &&
      !$past(PSEL && PENABLE && PWRITE) && PMEM_ADDR[10:0] != 11'h000;
  endsequence
  sequence call_dest;
    PMEM_ADDR[10:0] == {d2_r[7:5], d1_r};
  endsequence

  port_one_and_a : assert property ($changed(P1_OUT) |-> P1_OUT == $past(P1_IN & PMEM_DATA))
    else $error("port 1 latch is not pins and mask");
  port_two_and_a : assert property ($changed(P2_OUT) |-> P2_OUT == $past(P2_IN & PMEM_DATA))
    else $error("port 2 latch is not pins and mask");
  bus_latch_and_a : assert property ($changed(BUS_OUT) |->
    BUS_OUT == ($past(BUS_OUT) & $past(PMEM_DATA)))
    else $error("bus latch is not old latch and mask");
  call_target_a : assert property (call_jump |-> call_dest)
    else $error("call target does not match opcode and operand");
  exp_command_a : assert property (EXP_AND_STB |-> d2_r[7:2] == 6'h27 &&
    EXP_PORT == d2_r[1:0] && PMEM_ADDR == $past(PMEM_ADDR))
    else $error("expander strobe without its opcode");
  exp_pulse_one_a : assert property (EXP_AND_STB |=> !EXP_AND_STB)
    else $error("expander strobe longer than one cycle");
  exp_hold_a : assert property (($changed(EXP_PORT) || $changed(EXP_NIBBLE)) |-> EXP_AND_STB)
    else $error("expander fields changed without strobe");
  ready_high_a : assert property (PREADY)
    else $error("ready low");
  rdata_stands_a : assert property (!$past(PSEL && !PENABLE) |-> $stable(PRDATA))
    else $error("read data changed outside setup");
endmodule : m8ace_top_chk
`default_nettype wire

// ===== test/m8ace_pmem_model.sv
// program memory model: combinational byte store
`timescale 1ns/100ps
`default_nettype none
module m8ace_pmem_model (
  input  wire logic [11:0] addr,   // program counter
  output logic      [7:0]  data    // byte at addr
);
  logic [7:0] rom [0:4095];
  // opcode then operand, bench places calls clear of bank ends
  assign data = rom[addr];
endmodule : m8ace_pmem_model
`default_nettype wire

// ===== test/m8ace_top_test.sv
// self-checking bench for the execute block
`timescale 1ns/100ps
`default_nettype none
`include "m8ace_defines.svh"
module m8ace_top_test;
  logic        CORE_CLK = 1'b0;
  logic        NRST     = 1'b0;
  logic        PSEL     = 1'b0;
  logic        PENABLE  = 1'b0;
  logic        PWRITE   = 1'b0;
  logic [11:0] PADDR    = 12'h000;
  logic [31:0] PWDATA   = 32'h0000_0000;
  logic [7:0]  P1_IN    = 8'h3C;
  logic [7:0]  P2_IN    = 8'hA5;
  logic [31:0] PRDATA;
  logic        PREADY;
  logic        PSLVERR;
  logic [11:0] PMEM_ADDR;
  logic [7:0]  PMEM_DATA;
  logic [7:0]  BUS_OUT;
  logic [7:0]  P1_OUT;
  logic [7:0]  P2_OUT;
  logic        EXP_AND_STB;
  logic [1:0]  EXP_PORT;
  logic [3:0]  EXP_NIBBLE;
  int          err_count = 0;
  int          tests_run = 0;
  int          exp_seen  = 0;
  logic [1:0]  exp_port_s;
  logic [3:0]  exp_nib_s;
  logic [31:0] q;
  logic        e;
  // clear flags and acc, adds, ands on acc and ports, expander, add, call 0x920
  logic [7:0]  prog [0:23] = '{8'hA5, 8'h85, 8'h27, 8'h03, 8'h05, 8'h61, 8'h68, 8'h13,
                               8'h10, 8'h53, 8'h0F, 8'h50, 8'h5A, 8'h99, 8'hF0, 8'h9A,
                               8'h0F, 8'h98, 8'h55, 8'h9D, 8'h03, 8'hFF, 8'h34, 8'h20};
  // bank one carry-in forms, indirect add, an unlisted code, call 0x040
  logic [7:0]  prog2 [0:5] = '{8'h78, 8'h71, 8'h60, 8'h01, 8'h14, 8'h40};

  always #20 CORE_CLK = ~CORE_CLK;

  m8ace_top m8ace_top_i (
    .CORE_CLK(CORE_CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .PMEM_ADDR(PMEM_ADDR), .PMEM_DATA(PMEM_DATA), .BUS_OUT(BUS_OUT), .P1_IN(P1_IN),
    .P1_OUT(P1_OUT), .P2_IN(P2_IN), .P2_OUT(P2_OUT), .EXP_AND_STB(EXP_AND_STB),
    .EXP_PORT(EXP_PORT), .EXP_NIBBLE(EXP_NIBBLE));
  m8ace_pmem_model m8ace_pmem_model_i (.addr(PMEM_ADDR), .data(PMEM_DATA));

  always @(posedge CORE_CLK) begin
    if (EXP_AND_STB === 1'b1) begin
      exp_seen   <= exp_seen + 1;
      exp_port_s <= EXP_PORT;
      exp_nib_s  <= EXP_NIBBLE;
    end
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize

  task automatic check(input logic [31:0] seen, input logic [31:0] expd);
    tests_run++;
    if (seen !== expd) begin
      err_count++;
      $display("BAD %0t: got %h want %h", $time, seen, expd);
    end
  endtask : check

  // one apb transfer; request held until ready is seen at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge CORE_CLK);
    PSEL    <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE  <= w;
    PADDR   <= a;
    PWDATA  <= d;
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    do @(posedge CORE_CLK); while (PREADY !== 1'b1);
    q = PRDATA;
    e = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] expd, input logic experr);
    apb(1'b0, a, 32'h0000_0000);
    check(q, expd);
    check({31'h0, e}, {31'h0, experr});
  endtask : rd

  initial begin
    repeat (5000) @(posedge CORE_CLK);
    err_count++;
    summarize();
  end

  initial begin
    for (int k = 0; k < 4096; k++)
      m8ace_pmem_model_i.rom[k] = (k < 24) ? prog[k] : 8'h97;
    repeat (10) @(posedge CORE_CLK);
    NRST <= 1'b1;
    rd(`M8ACE_OFS_PORTS, 32'h00FF_FFFF, 1'b0);
    rd(12'h010, 32'h0000_0000, 1'b1);
    // r0 doubles as a pointer whose top bits must be dropped
    wr(`M8ACE_OFS_DMEM, 32'h0000_00FC);
    wr(`M8ACE_OFS_DMEM + 12'h004, 32'h0000_0020);
    wr(`M8ACE_OFS_DMEM + 12'h008, 32'h0000_0006);
    wr(`M8ACE_OFS_DMEM + 12'h080, 32'h0000_0003);
    wr(`M8ACE_OFS_DMEM + 12'h0F0, 32'h0000_0006);
    wr(`M8ACE_OFS_STATUS, 32'h0001_2077);
    // run with the bank flag set so the call lands in the upper bank
    wr(`M8ACE_OFS_CTRL, 32'h0000_0003);
    for (int k = 0; k < 200 && PMEM_ADDR !== 12'h920; k++)
      @(posedge CORE_CLK);
    check({20'h0, PMEM_ADDR}, 32'h0000_0920);
    wr(`M8ACE_OFS_CTRL, 32'h0000_0000);
    rd(`M8ACE_OFS_STATUS, 32'h0000_4903, 1'b0);
    // bus mask uses the latch left by reset in place of a prior output
    rd(`M8ACE_OFS_PORTS, 32'h0005_3055, 1'b0);
    rd(`M8ACE_OFS_DMEM + 12'h020, 32'h0000_0018, 1'b0);
    rd(`M8ACE_OFS_DMEM + 12'h024, 32'h0000_00C0, 1'b0);
    check(exp_seen, 32'd1);
    check({30'h0, exp_port_s}, 32'h0000_0001);
    check({28'h0, exp_nib_s}, 32'h0000_0004);
    // reset while halted, then run the second program from address zero
    @(posedge CORE_CLK);
    NRST <= 1'b0;
    for (int k = 0; k < 6; k++)
      m8ace_pmem_model_i.rom[k] <= prog2[k];
    repeat (3) @(posedge CORE_CLK);
    NRST <= 1'b1;
    rd(`M8ACE_OFS_PORTS, 32'h00FF_FFFF, 1'b0);
    rd(`M8ACE_OFS_PC, 32'h0000_0000, 1'b0);
    rd(`M8ACE_OFS_STATUS, 32'h0000_0800, 1'b0);
    wr(`M8ACE_OFS_DMEM + 12'h060, 32'h0000_0020);
    wr(`M8ACE_OFS_DMEM + 12'h064, 32'h0000_0028);
    wr(`M8ACE_OFS_DMEM + 12'h080, 32'h0000_0002);
    wr(`M8ACE_OFS_DMEM + 12'h0A0, 32'h0000_00F0);
    wr(`M8ACE_OFS_STATUS, 32'h0000_8010);
    // register bank one, bank flag clear
    wr(`M8ACE_OFS_CTRL, 32'h0000_0005);
    for (int k = 0; k < 200 && PMEM_ADDR !== 12'h040; k++)
      @(posedge CORE_CLK);
    check({20'h0, PMEM_ADDR}, 32'h0000_0040);
    wr(`M8ACE_OFS_CTRL, 32'h0000_0004);
    rd(`M8ACE_OFS_STATUS, 32'h0002_1923, 1'b0);
    rd(`M8ACE_OFS_DMEM + 12'h020, 32'h0000_0006, 1'b0);
    rd(`M8ACE_OFS_DMEM + 12'h024, 32'h0000_0010, 1'b0);
    wr(`M8ACE_OFS_STATUS, 32'h0002_0000);
    rd(`M8ACE_OFS_STATUS, 32'h0000_0800, 1'b0);
    summarize();
  end
endmodule : m8ace_top_test

bind m8ace_top m8ace_top_chk m8ace_top_chk_i (
  .CORE_CLK(CORE_CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PRDATA(PRDATA), .PREADY(PREADY), .PMEM_ADDR(PMEM_ADDR), .PMEM_DATA(PMEM_DATA),
  .BUS_OUT(BUS_OUT), .P1_IN(P1_IN), .P1_OUT(P1_OUT), .P2_IN(P2_IN), .P2_OUT(P2_OUT),
  .EXP_AND_STB(EXP_AND_STB), .EXP_PORT(EXP_PORT), .EXP_NIBBLE(EXP_NIBBLE));
`default_nettype wire
